// *** rtcm_defs.vh ***
`ifndef RTCM_DEFS_VH
`define RTCM_DEFS_VH

// Register indices; the bus byte address is four times the index.
`define RTCM_IDX_FLAGS     4'h0
`define RTCM_IDX_CENTURY   4'h1
`define RTCM_IDX_ALM_SEC   4'h2
`define RTCM_IDX_ALM_MIN   4'h3
`define RTCM_IDX_ALM_HOUR  4'h4
`define RTCM_IDX_ALM_DATE  4'h5
`define RTCM_IDX_INTCTL    4'h6
`define RTCM_IDX_WDOG      4'h7
`define RTCM_IDX_TRIM      4'h8
`define RTCM_IDX_SEC       4'h9
`define RTCM_IDX_MIN       4'ha
`define RTCM_IDX_HOUR      4'hb
`define RTCM_IDX_WDAY      4'hc
`define RTCM_IDX_DATE      4'hd
`define RTCM_IDX_MONTH     4'he
`define RTCM_IDX_YEAR      4'hf
`define RTCM_IDX_IRQ_STAT  5'h10
`define RTCM_IDX_IRQ_MASK  5'h11
`define RTCM_IDX_TICK_DIV  5'h12

// Flags register bit positions.
`define RTCM_FLG_WDOG      7
`define RTCM_FLG_ALARM     6
`define RTCM_FLG_PFAIL     5
`define RTCM_FLG_OSCILLATOR_FAIL_FLAG      4
`define RTCM_FLG_BPF       3

// Factory defaults.
`define RTCM_RST_ALARM     8'h80
`define RTCM_RST_INTCTL    8'h08
`define RTCM_RST_ZERO      8'h00
`define RTCM_RST_FLAGS     8'h18
`define RTCM_RST_WDAY      8'h01
`define RTCM_RST_DATE      8'h01
`define RTCM_RST_MONTH     8'h01

// Field masks of used bits per register.
`define RTCM_MSK_SEC       8'h7f
`define RTCM_MSK_HOUR      8'h3f
`define RTCM_MSK_WDAY      8'h07
`define RTCM_MSK_MONTH     8'h1f
`define RTCM_MSK_ALM_SEC   8'hff
`define RTCM_MSK_ALM_HOUR  8'hbf
`define RTCM_MSK_TRIM      8'hbf

// Interrupt status bits.
`define RTCM_IRQ_SECOND    0
`define RTCM_IRQ_ALARM     1
`define RTCM_IRQ_FLAGUPD   2

// Flag update delay and tick rate.
`define RTCM_CLK_MHZ       50
`define RTCM_UPD_US        2
`define RTCM_UPD_CYC       (`RTCM_UPD_US * `RTCM_CLK_MHZ)
`define RTCM_TICK_DEFAULT  32'h02faf080

`endif

// *** rtcm_regmem.v ***
`timescale 1ns/10ps
`include "rtcm_defs.vh"

// Sixteen-byte register store with a registered read port.
module rtcm_regmem (
	// Clock and reset.
	input  wire       pclk,
	input  wire       presetn,
	// Write port.
	input  wire       wr_en,
	input  wire [3:0] wr_idx,
	input  wire [7:0] wr_data,
	// Read port.
	input  wire [3:0] rd_idx,
	output reg  [7:0] rd_data,
	// Whole-array view for the timekeeping logic.
	output wire [127:0] all_bytes
);
	reg [7:0] mem_r [0:15];
	genvar g;

	// Each byte is exported so the counter logic can see the whole calendar at once.
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_exp
			assign all_bytes[g*8 +: 8] = mem_r[g];
		end
	endgenerate

	// The store resets to the factory image.
	integer i;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < 16; i = i + 1)
				mem_r[i] <= `RTCM_RST_ZERO;
			mem_r[`RTCM_IDX_ALM_SEC]  <= `RTCM_RST_ALARM;
			mem_r[`RTCM_IDX_ALM_MIN]  <= `RTCM_RST_ALARM;
			mem_r[`RTCM_IDX_ALM_HOUR] <= `RTCM_RST_ALARM;
			mem_r[`RTCM_IDX_ALM_DATE] <= `RTCM_RST_ALARM;
			mem_r[`RTCM_IDX_INTCTL]   <= `RTCM_RST_INTCTL;
			mem_r[`RTCM_IDX_FLAGS]    <= `RTCM_RST_FLAGS;
			mem_r[`RTCM_IDX_WDAY]     <= `RTCM_RST_WDAY;
			mem_r[`RTCM_IDX_DATE]     <= `RTCM_RST_DATE;
			mem_r[`RTCM_IDX_MONTH]    <= `RTCM_RST_MONTH;
			rd_data <= `RTCM_RST_ZERO;
		end else begin
			if (wr_en)
				mem_r[wr_idx] <= wr_data;
			rd_data <= mem_r[rd_idx];
		end
	end
endmodule // rtcm_regmem

// *** rtcm_top.v ***
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "rtcm_defs.vh"

module rtcm_top (
	// APB slave.
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Interrupt.
	output reg         irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_DONE = 3'b100;

	// Bus answer, tick, interrupt and flag update state.
	reg  [2:0]   state_r;
	reg  [31:0]  tick_div_r;
	reg  [31:0]  tick_cnt_r;
	reg  [2:0]   irq_stat_r;
	reg  [2:0]   irq_mask_r;
	reg  [6:0]   upd_cnt_r;
	reg          upd_pend_r;
	reg  [7:0]   upd_val_r;
	reg          mem_we;
	reg  [3:0]   mem_widx;
	reg  [7:0]   mem_wdat;
	wire [7:0]   mem_rdat;
	wire [127:0] bytes;
	reg          tick;
	reg          alarm_hit;

	wire        acc    = psel & penable & ~pready;
	wire        wr_acc = acc & pwrite;
	wire [9:0]  idx    = paddr[11:2];
	wire        in_mem = (idx < 10'h010);
	wire [7:0]  wbyte  = pwdata[7:0];
	// Bus writes to the stored bytes other than flags own the shared write port in both wait states of the access.
	wire        bus_mem_we = wr_acc & in_mem & (idx[3:0] != `RTCM_IDX_FLAGS);
	// The delayed flags load only counts as done in a cycle in which it really got the port;
	// otherwise a colliding bus write would silently drop the cleared fail bits.
	wire        upd_load = upd_pend_r & (upd_cnt_r == 7'h00) & ~bus_mem_we;
	// Start value of the flag update counter, cut to the counter width on purpose.
	wire [31:0] upd_start_cnt = `RTCM_UPD_CYC - 1;

	// Used-bit mask per register so reserved bits always read back as zero.
	// The same mask guards writes, so a reserved bit is never stored even if software sets it.
	function [7:0] field_mask;
		input [3:0] i;
		begin
			case (i)
				`RTCM_IDX_SEC, `RTCM_IDX_MIN:           field_mask = `RTCM_MSK_SEC;
				`RTCM_IDX_HOUR, `RTCM_IDX_DATE:         field_mask = `RTCM_MSK_HOUR;
				`RTCM_IDX_WDAY:                         field_mask = `RTCM_MSK_WDAY;
				`RTCM_IDX_MONTH:                        field_mask = `RTCM_MSK_MONTH;
				`RTCM_IDX_ALM_DATE, `RTCM_IDX_ALM_HOUR: field_mask = `RTCM_MSK_ALM_HOUR;
				`RTCM_IDX_TRIM:                         field_mask = `RTCM_MSK_TRIM;
				default:                                field_mask = 8'hff;
			endcase
		end
	endfunction

	// Increments a BCD byte, wrapping from the top value to the low value.
	function [7:0] bcd_inc;
		input [7:0] v;
		input [7:0] top;
		input [7:0] low;
		begin
			if (v >= top)
				bcd_inc = low;
			else if (v[3:0] >= 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// An alarm field matches when its disable bit is set or the value agrees.
	function fld_ok;
		input [7:0] a;
		input [7:0] t;
		begin
			fld_ok = a[7] | (a[6:0] == t[6:0]);
		end
	endfunction

	rtcm_regmem u_mem (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr_en     (mem_we),
		.wr_idx    (mem_widx),
		.wr_data   (mem_wdat),
		.rd_idx    (idx[3:0]),
		.rd_data   (mem_rdat),
		.all_bytes (bytes)
	);

	wire [7:0] b_flags = bytes[8*`RTCM_IDX_FLAGS +: 8];
	wire [7:0] b_sec   = bytes[8*`RTCM_IDX_SEC +: 8];
	wire [7:0] b_min   = bytes[8*`RTCM_IDX_MIN +: 8];
	wire [7:0] b_hour  = bytes[8*`RTCM_IDX_HOUR +: 8];
	wire [7:0] b_wday  = bytes[8*`RTCM_IDX_WDAY +: 8];
	wire [7:0] b_date  = bytes[8*`RTCM_IDX_DATE +: 8];
	wire [7:0] b_month = bytes[8*`RTCM_IDX_MONTH +: 8];
	wire [7:0] b_year  = bytes[8*`RTCM_IDX_YEAR +: 8];
	wire [7:0] b_cent  = bytes[8*`RTCM_IDX_CENTURY +: 8];
	wire [7:0] b_ctl   = bytes[8*`RTCM_IDX_INTCTL +: 8];
	wire       osc_run = bytes[8*`RTCM_IDX_TRIM + 7] == 1'b0;

	// One-second tick from pclk; the trim byte stops the clock when its bit 7 is set.
	// The divider register lets a bench shorten the second; a zero divider is refused,
	// though a divider of one still fires the tick on every cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 32'h00000000;
			tick       <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (!osc_run) begin
				tick_cnt_r <= 32'h00000000;
			end else if (tick_cnt_r >= tick_div_r - 32'h00000001) begin
				tick_cnt_r <= 32'h00000000;
				tick       <= 1'b1;
			end else begin
				tick_cnt_r <= tick_cnt_r + 32'h00000001;
			end
		end
	end

	// Alarm compare, checked on the updated time in the cycle after the carry chain ends.
	// With every field disabled the compare would match each second, so that case
	// is held off and an alarm needs at least one enabled field.
	always @* begin
		alarm_hit = fld_ok(bytes[8*`RTCM_IDX_ALM_SEC +: 8], b_sec) &
		            fld_ok(bytes[8*`RTCM_IDX_ALM_MIN +: 8], b_min) &
		            fld_ok(bytes[8*`RTCM_IDX_ALM_HOUR +: 8], b_hour) &
		            fld_ok(bytes[8*`RTCM_IDX_ALM_DATE +: 8], b_date) &
		            ~(bytes[8*`RTCM_IDX_ALM_SEC + 7] & bytes[8*`RTCM_IDX_ALM_MIN + 7] &
		              bytes[8*`RTCM_IDX_ALM_HOUR + 7] & bytes[8*`RTCM_IDX_ALM_DATE + 7]);
	end

	// One write port is shared; bus writes win, then the delayed flag load, then the
	// calendar carry chain. The carry advances one register per cycle, which keeps the
	// adder small at the cost of a few cycles of ripple after each second.
	// Date_count wraps at 31 for every month; software that needs real month
	// lengths must correct the date itself.
	reg [3:0] carry_idx_r;
	reg       carry_on_r;
	reg       alarm_chk_r;
	always @* begin
		mem_we   = 1'b0;
		mem_widx = 4'h0;
		mem_wdat = 8'h00;
		if (bus_mem_we) begin
			mem_we   = 1'b1;
			mem_widx = idx[3:0];
			mem_wdat = wbyte & field_mask(idx[3:0]);
		end else if (upd_load) begin
			mem_we   = 1'b1;
			mem_widx = `RTCM_IDX_FLAGS;
			mem_wdat = upd_val_r;
		end else if (carry_on_r) begin
			mem_we   = 1'b1;
			mem_widx = carry_idx_r;
			case (carry_idx_r)
				`RTCM_IDX_SEC:   mem_wdat = bcd_inc(b_sec, 8'h59, 8'h00);
				`RTCM_IDX_MIN:   mem_wdat = bcd_inc(b_min, 8'h59, 8'h00);
				`RTCM_IDX_HOUR:  mem_wdat = bcd_inc(b_hour, 8'h23, 8'h00);
				`RTCM_IDX_WDAY:  mem_wdat = bcd_inc(b_wday, 8'h07, 8'h01);
				`RTCM_IDX_DATE:  mem_wdat = bcd_inc(b_date, 8'h31, 8'h01);
				`RTCM_IDX_MONTH: mem_wdat = bcd_inc(b_month, 8'h12, 8'h01);
				`RTCM_IDX_YEAR:  mem_wdat = bcd_inc(b_year, 8'h99, 8'h00);
				default:         mem_wdat = bcd_inc(b_cent, 8'h99, 8'h00);
			endcase
		end
	end

	// Carry chain sequencing: each field but the weekday passes the carry on only when it wrapped.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_on_r  <= 1'b0;
			carry_idx_r <= 4'h0;
			alarm_chk_r <= 1'b0;
		end else begin
			alarm_chk_r <= 1'b0;
			if (tick) begin
				carry_on_r  <= 1'b1;
				carry_idx_r <= `RTCM_IDX_SEC;
			// A carry step only counts in a cycle in which the port took the carry write.
			end else if (carry_on_r && mem_widx == carry_idx_r && !bus_mem_we) begin
				if (carry_idx_r == `RTCM_IDX_SEC && b_sec != 8'h59 ||
				    carry_idx_r == `RTCM_IDX_MIN && b_min != 8'h59 ||
				    carry_idx_r == `RTCM_IDX_HOUR && b_hour != 8'h23 ||
				    carry_idx_r == `RTCM_IDX_DATE && b_date != 8'h31 ||
				    carry_idx_r == `RTCM_IDX_MONTH && b_month != 8'h12 ||
				    carry_idx_r == `RTCM_IDX_YEAR && b_year != 8'h99 ||
				    carry_idx_r == `RTCM_IDX_CENTURY) begin
					carry_on_r  <= 1'b0;
					alarm_chk_r <= 1'b1;
				end else if (carry_idx_r == `RTCM_IDX_YEAR) begin
					carry_idx_r <= `RTCM_IDX_CENTURY;
				end else begin
					carry_idx_r <= carry_idx_r + 4'h1;
				end
			end
		end
	end

	// Bus write to the flags byte: zeros in the fail positions clear them after a fixed
	// delay; a second write during the delay restarts it with the newer value.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_pend_r <= 1'b0;
			upd_cnt_r  <= 7'h00;
			upd_val_r  <= `RTCM_RST_FLAGS;
		end else if (wr_acc && in_mem && idx[3:0] == `RTCM_IDX_FLAGS) begin
			upd_pend_r <= 1'b1;
			upd_cnt_r  <= upd_start_cnt[6:0];
			upd_val_r  <= {b_flags[7:5], wbyte[4:3] & b_flags[4:3], wbyte[2:0] & 3'h7};
		end else if (upd_load) begin
			// The load waits at zero while a bus write holds the port, then retires.
			upd_pend_r <= 1'b0;
		end else if (upd_pend_r && upd_cnt_r != 7'h00) begin
			upd_cnt_r <= upd_cnt_r - 7'h01;
		end
	end

	// Bus answer: register reads take two wait states for the memory read port.
	// Writes answer with zero read data, so a stale byte from an earlier read never
	// looks like an echo of the written value.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (acc)
						state_r <= ST_WAIT;
				end
				ST_WAIT: begin
					pready  <= 1'b1;
					state_r <= ST_DONE;
					pslverr <= (idx > `RTCM_IDX_TICK_DIV);
					if (pwrite || idx > `RTCM_IDX_TICK_DIV)
						prdata <= 32'h00000000;
					else if (in_mem)
						prdata <= {24'h000000, mem_rdat & field_mask(idx[3:0])};
					else if (idx == `RTCM_IDX_IRQ_STAT)
						prdata <= {29'h0, irq_stat_r};
					else if (idx == `RTCM_IDX_IRQ_MASK)
						prdata <= {29'h0, irq_mask_r};
					else
						prdata <= tick_div_r;
				end
				ST_DONE: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Extra registers: sticky status (write one to clear, set wins), mask, tick divider.
	// The interrupt output is registered, so it trails status and mask by one cycle;
	// the flag update event is the cycle in which the delayed load really lands.
	wire [2:0] ev = {upd_load, alarm_chk_r & alarm_hit, tick};
	wire       wr_done = psel & penable & pready & pwrite;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 3'h0;
			irq_mask_r <= 3'h0;
			tick_div_r <= `RTCM_TICK_DEFAULT;
			irq        <= 1'b0;
		end else begin
			if (wr_done && idx == `RTCM_IDX_IRQ_STAT)
				irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | ev;
			else
				irq_stat_r <= irq_stat_r | ev;
			if (wr_done && idx == `RTCM_IDX_IRQ_MASK)
				irq_mask_r <= pwdata[2:0];
			if (wr_done && idx == `RTCM_IDX_TICK_DIV && pwdata != 32'h00000000)
				tick_div_r <= pwdata;
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end
endmodule // rtcm_top

// *** rtcm_props.sv ***
`timescale 1ns/10ps
// Watches the bus face of the clock register bank.
module rtcm_props (
	// Bus and interrupt.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       rd_ok;
	logic [7:0] upd_cnt_r;
	logic [1:0] shown_r;
	// Read data only means something on the answering edge of a read.
	assign rd_ok = pready && !pwrite;
	// Age of the last flags write and the fail bits last shown, so early reads can be judged.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_cnt_r <= 8'hff;
			shown_r   <= 2'b11;
		end else begin
			if (pready && pwrite && paddr == 12'h000)
				upd_cnt_r <= 8'h00;
			else if (upd_cnt_r != 8'hff)
				upd_cnt_r <= upd_cnt_r + 8'h01;
			if (rd_ok && paddr == 12'h000)
				shown_r <= prdata[4:3];
		end
	end
	a_ready_delay: assert property ($rose(penable) && psel |-> !pready ##2 pready)
		else $error("answer not two cycles after access start");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_index: assert property (pready |-> pslverr == (paddr[11:2] > 10'h012))
		else $error("error flag does not match index");
	a_flag_hold: assert property (rd_ok && paddr == 12'h000 && upd_cnt_r < 8'd90 |-> prdata[4:3] == shown_r)
		else $error("fail flags changed inside update delay");
	a_wday_range: assert property (rd_ok && paddr == 12'h030 |-> prdata[31:3] == 0 && prdata[2:0] != 0)
		else $error("weekday out of range");
	a_month_bits: assert property (rd_ok && paddr == 12'h038 |-> prdata[31:5] == 0)
		else $error("month unused bits set");
	a_year_bcd: assert property (rd_ok && paddr == 12'h03c |-> prdata[7:4] <= 4'h9 && prdata[3:0] <= 4'h9)
		else $error("year nibble not a decimal digit");
	a_alarm_date: assert property (rd_ok && paddr == 12'h014 |-> prdata[6] == 1'b0 && prdata[31:8] == 0)
		else $error("alarm date reserved bit set");
	a_sec_bcd: assert property (rd_ok && paddr == 12'h024 |-> prdata[7] == 1'b0 && prdata[6:4] <= 3'h5)
		else $error("seconds out of range");
	cover property (rd_ok && paddr == 12'h000);
	cover property (pslverr);
	cover property ($rose(irq));
endmodule // rtcm_props

bind rtcm_top rtcm_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int          fails, cmp_count, k;
	logic [7:0]  rst_v [16] = '{8'h18, 0, 8'h80, 8'h80, 8'h80, 8'h80, 8'h08, 0, 0, 0, 0, 0, 8'h01, 8'h01, 8'h01, 0};
	logic [3:0]  rw_i [8] = '{4'h8, 4'h7, 4'h6, 4'hc, 4'he, 4'h1, 4'h5, 4'hf};
	logic [7:0]  rw_w [8] = '{8'h25, 8'h3c, 8'h5a, 8'hff, 8'hff, 8'h42, 8'hb1, 8'h45};
	logic [7:0]  rw_e [8] = '{8'h25, 8'h3c, 8'h5a, 8'h07, 8'h1f, 8'h42, 8'hb1, 8'h45};
	logic [3:0]  tm_i [8] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h1};
	logic [7:0]  tm_w [8] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h20};
	logic [7:0]  tm_e [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h21};

	rtcm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

	// Free-running 50 MHz bus clock.
	always #10 pclk = ~pclk;

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask

	// One bus transfer; the request stands until ready is sampled high.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] i, input logic [31:0] d);
		bus(1'b1, {5'h0, i, 2'b00}, d);
	endtask

	task automatic rd(input logic [4:0] i, input logic [7:0] x);
		bus(1'b0, {5'h0, i, 2'b00}, 0);
		chk(q, {24'h0, x});
	endtask

	// Polls the second-tick status bit; bounded so a dead divider cannot hang the run.
	task automatic wait_tick();
		int n;
		n = 0;
		do begin
			bus(1'b0, 12'h040, 0);
			n++;
		end while (q[0] !== 1'b1 && n < 200);
		chk(q & 32'h1, 32'h1);
	endtask

	task automatic complete_run();
		$display("mismatches %0d compares %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 0;
		pwdata = 0;
		fails = 0;
		cmp_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 16; k++)
			rd(k[4:0], rst_v[k]);
		for (k = 0; k < 8; k++) begin
			wr({1'b0, rw_i[k]}, {24'h0, rw_w[k]});
			rd({1'b0, rw_i[k]}, rw_e[k]);
		end
		bus(1'b0, 12'h04c, 0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		// Clearing the fail flags must not show before the update delay ends.
		wr(5'h00, 32'h0);
		bus(1'b0, 12'h000, 0);
		chk({30'h0, q[4:3]}, 32'h3);
		repeat (110) @(posedge pclk);
		bus(1'b0, 12'h000, 0);
		chk({30'h0, q[4:3]}, 32'h0);
		bus(1'b0, 12'h040, 0);
		chk(q & 32'h4, 32'h4);
		// Short second, then a year-end rollover with the tick interrupt unmasked.
		wr(5'h12, 32'd400);
		wr(5'h11, 32'h1);
		bus(1'b0, 12'h048, 0);
		chk(q, 32'd400);
		bus(1'b0, 12'h044, 0);
		chk(q, 32'h1);
		wait_tick();
		wr(5'h10, 32'h7);
		for (k = 0; k < 8; k++)
			wr({1'b0, tm_i[k]}, {24'h0, tm_w[k]});
		chk({31'h0, irq}, 32'h0);
		wait_tick();
		repeat (20) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		for (k = 0; k < 8; k++)
			rd({1'b0, tm_i[k]}, tm_e[k]);
		// No alarm field is enabled, so the rollover second must not raise the alarm bit.
		bus(1'b0, 12'h040, 0);
		chk(q & 32'h2, 32'h0);
		// Match on second 01 alone; the next tick lands there with the interrupt masked.
		wr(5'h02, 32'h01);
		wr(5'h11, 32'h0);
		wr(5'h10, 32'h7);
		wait_tick();
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 12'h040, 0);
		chk(q & 32'h2, 32'h2);
		complete_run();
	end

	// Watchdog: the whole sequence needs well under 1500 cycles.
	initial begin
		repeat (30000) @(posedge pclk);
		fails++;
		complete_run();
	end
endmodule // tb
